// >>> core/watch_interval_defines.svh
// Purpose: constants of the interval prescaler
// Assumes: included by bare name
// Notes:   offsets are byte addresses on the apb slave
`ifndef WATCH_INTERVAL_DEFINES_SVH
`define WATCH_INTERVAL_DEFINES_SVH

`define CTRL_OFFSET      12'h000
`define CTRL_RESET       8'h00
`define BIT_FLAG         7
`define BIT_IRQ_EN       6
`define BIT_RSVD_HI      5
`define BIT_RSVD_LO      4
`define BIT_SEL_HI       3
`define BIT_SEL_LO       1
`define BIT_CLEAR        0
`define COUNT_W          17
`define COUNT_ONES       17'h1_FFFF
`define WDT_TAP_BIT      16
`define SYNC_PINS        2

`endif

// >>> core/watch_interval_pkg.sv
// Purpose: types of the interval prescaler
// Assumes: nothing
// Notes:   the interval table lives here so both modules agree
package watch_interval_pkg;

    typedef logic [2:0]  interval_select_t;
    typedef logic [16:0] count_t;
    typedef logic [4:0]  exponent_t;

    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_SUB  = 2'b01,
        SRC_RC   = 2'b11
    } source_e;

    function automatic exponent_t interval_exponent(input interval_select_t sel);
        exponent_t k;
        k = 5'd11;
        case (sel)
            3'b100:  k = 5'd10;
            3'b000:  k = 5'd11;
            3'b001:  k = 5'd12;
            3'b010:  k = 5'd13;
            3'b011:  k = 5'd14;
            3'b101:  k = 5'd15;
            3'b110:  k = 5'd16;
            3'b111:  k = 5'd17;
            default: k = 5'd11;
        endcase
        return k;
    endfunction

endpackage

// >>> core/prescaler_if.sv
// Purpose: joins the control top to the prescaler counter
// Assumes: single pclk domain
// Notes:   tick and clear are one-cycle pulses
interface prescaler_if;
    logic                                tick;
    logic                                clear;
    watch_interval_pkg::interval_select_t sel;
    watch_interval_pkg::count_t          count;
    logic                                event_hit;

    modport ctrl (output tick, output clear, output sel, input count, input event_hit);
    modport core (input tick, input clear, input sel, output count, output event_hit);
endinterface

// >>> core/prescaler_counter.sv
// Purpose: down-counting prescaler with selectable interval tap
// Assumes: tick is one pclk pulse per half-rate count-clock period
// Notes:   17 stages so the longest interval of 2^17 ticks fits
`include "watch_interval_defines.svh"

module prescaler_counter (
    input  wire logic   pclk,
    input  wire logic   presetn,
    prescaler_if.core   pif
);

    watch_interval_pkg::count_t    mask;
    watch_interval_pkg::exponent_t k;

    always_comb begin
        k    = watch_interval_pkg::interval_exponent(pif.sel);
        mask = watch_interval_pkg::count_t'((18'h0_0001 << k) - 18'h0_0001);
    end

    // reset and clear both load all ones; wraps from zero to all ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pif.count <= `COUNT_ONES;
        end else if (pif.clear) begin
            pif.count <= `COUNT_ONES;
        end else if (pif.tick) begin
            pif.count <= pif.count - 17'h0_0001;
        end
    end

    // interval elapses when the low k bits roll from zero; clear suppresses it
    assign pif.event_hit = pif.tick && !pif.clear && ((pif.count & mask) == '0);

endmodule

// >>> core/watch_interval_prescaler.sv
// Purpose: interval prescaler on the low-speed clocks, apb control register
// Assumes: sub clocks arrive as pins far slower than pclk; mode inputs are on pclk
// Notes:   count clock is recovered by edge detection, not used as a clock
// Overview of operation
// - flag sets every selected interval since last clear, irrespective of enable; the code does not set it while sub_stop_mode is high.
// - interrupt request is high while flag and enable are both one.
// - flag reads its state; writing zero clears, writing one keeps it.
// - read-modify-write reads return one for the flag bit.
// - enable bit gates the request output to the interrupt controller.
// - bits five and four read zero and ignore writes.
// - select field picks 2^10 to 2^17 half-rate periods per table.
// - writing one to clear bit loads all ones into the counter.
// - clear bit always reads zero.
// - clearing also clears watchdog counter when watchdog uses a tap.
// - in main-clock stop modes counting, flag and interrupt keep working.
// - watchdog tap restarts from initial phase together with its counter clear.
// - seventeen-bit down count from all ones, wrapping zero to all ones.
// - count clock is subclock or sub-rc halved, subclock preferred.
// - clear coinciding with tap overflow does not set the flag.
// - reset, stop from sub mode, or dropped enable in main mode clear.
//
// Implementation choices: the APB slave port and the register offsets.
`include "watch_interval_defines.svh"

module watch_interval_prescaler (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rmw_access,
    input  wire logic        subclk_pin,
    input  wire logic        subrc_pin,
    input  wire logic        sub_osc_enable,
    input  wire logic        subrc_osc_enable,
    input  wire logic        sub_stable,
    input  wire logic        subrc_stable,
    input  wire logic        main_clock_mode,
    input  wire logic        sub_stop_mode,
    input  wire logic        stop_entry_from_sub,
    input  wire logic        wdt_uses_tap,
    output logic             wdt_tap,
    output logic             wdt_clear,
    output logic             irq
);

    prescaler_if pif ();

    prescaler_counter u_counter (
        .pclk    (pclk),
        .presetn (presetn),
        .pif     (pif)
    );

    logic [`SYNC_PINS-1:0]          pin_raw;
    logic [`SYNC_PINS-1:0]          sync1;
    logic [`SYNC_PINS-1:0]          sync2;
    logic [`SYNC_PINS-1:0]          sync3;
    logic [`SYNC_PINS-1:0]          pin_rise;
    watch_interval_pkg::source_e    src;
    logic                           src_rise;
    logic                           half_div;
    logic                           flag;
    logic                           irq_enable;
    watch_interval_pkg::interval_select_t sel;
    logic                           sub_en_d;
    logic                           rc_en_d;
    logic                           addr_hit;
    logic                           wr_access;
    logic                           sw_clear;
    logic                           osc_drop;
    logic                           any_clear;

    assign pin_raw = {subrc_pin, subclk_pin};

    // two flops before use; the third only feeds the edge detector
    genvar i;
    generate
        for (i = 0; i < `SYNC_PINS; i++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1[i] <= 1'b0;
                    sync2[i] <= 1'b0;
                    sync3[i] <= 1'b0;
                end else begin
                    sync1[i] <= pin_raw[i];
                    sync2[i] <= sync1[i];
                    sync3[i] <= sync2[i];
                end
            end
            assign pin_rise[i] = sync2[i] & ~sync3[i];
        end
    endgenerate

    // subclock wins when both are enabled and stable
    always_comb begin
        if (sub_osc_enable && sub_stable) begin
            src = watch_interval_pkg::SRC_SUB;
        end else if (subrc_osc_enable && subrc_stable) begin
            src = watch_interval_pkg::SRC_RC;
        end else begin
            src = watch_interval_pkg::SRC_NONE;
        end
        case (src)
            watch_interval_pkg::SRC_SUB: src_rise = pin_rise[0];
            watch_interval_pkg::SRC_RC:  src_rise = pin_rise[1];
            default:                     src_rise = 1'b0;
        endcase
    end

    // divide by two; restarting the divider on clear keeps the tap phase exact
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_div <= 1'b0;
        end else if (any_clear) begin
            half_div <= 1'b0;
        end else if (src_rise) begin
            half_div <= ~half_div;
        end
    end

    // counting needs only a running source, so main-clock stop keeps going
    assign pif.tick  = src_rise && half_div;
    assign pif.sel   = sel;
    assign pif.clear = any_clear;

    assign addr_hit  = (paddr == `CTRL_OFFSET);
    assign wr_access = psel && penable && pwrite && addr_hit;
    assign sw_clear  = wr_access && pwdata[`BIT_CLEAR];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_en_d <= 1'b0;
            rc_en_d  <= 1'b0;
        end else begin
            sub_en_d <= sub_osc_enable;
            rc_en_d  <= subrc_osc_enable;
        end
    end

    assign osc_drop  = main_clock_mode && ((sub_en_d && !sub_osc_enable) || (rc_en_d && !subrc_osc_enable));
    assign any_clear = sw_clear || osc_drop || stop_entry_from_sub;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel        <= 3'h0;
            irq_enable <= 1'b0;
        end else if (wr_access) begin
            sel        <= pwdata[`BIT_SEL_HI:`BIT_SEL_LO];
            irq_enable <= pwdata[`BIT_IRQ_EN];
        end
    end

    // set beats a same-cycle write of zero; flag is held off in sub-clock stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= 1'b0;
        end else if (pif.event_hit && !sub_stop_mode) begin
            flag <= 1'b1;
        end else if (wr_access && !pwdata[`BIT_FLAG]) begin
            flag <= 1'b0;
        end
    end

    assign irq = flag && irq_enable;

    // read data is captured in the setup phase so it stands as a flop output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            if (addr_hit && !pwrite) begin
                prdata <= {24'h00_0000, flag | rmw_access, irq_enable, 2'b00, sel, 1'b0};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    // tap and watchdog clear move on the same edge so the watchdog period holds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_clear <= 1'b0;
        end else begin
            wdt_clear <= any_clear && wdt_uses_tap;
        end
    end

    assign wdt_tap = pif.count[`WDT_TAP_BIT];

    sequence s_write_zero_flag;
        wr_access && !pwdata[`BIT_FLAG] && !pif.event_hit;
    endsequence

    sequence s_read_setup;
        psel && !penable && addr_hit && !pwrite;
    endsequence

    sequence s_write_one_flag;
        wr_access && pwdata[`BIT_FLAG];
    endsequence

    // an enable that drops while main clocking runs restarts the count
    sequence s_osc_drop;
        main_clock_mode && ((sub_en_d && !sub_osc_enable) || (rc_en_d && !subrc_osc_enable));
    endsequence

    a_flag_on_event: assert property (@(posedge pclk) disable iff (!presetn)
        (pif.event_hit && !sub_stop_mode) |=> flag)
        else $error("flag not set after interval");

    a_irq_follows_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (pif.event_hit && !sub_stop_mode && irq_enable && !wr_access) |=> irq)
        else $error("request missing after flagged interval");

    a_flag_write_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_zero_flag |=> !flag)
        else $error("flag not cleared by zero write");

    a_rmw_reads_one: assert property (@(posedge pclk) disable iff (!presetn)
        (s_read_setup ##0 rmw_access) |=> prdata[`BIT_FLAG])
        else $error("rmw read of flag returned zero");

    a_enable_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_access && !pwdata[`BIT_IRQ_EN]) |=> !irq)
        else $error("request passed with enable low");

    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_setup |=> (prdata[`BIT_RSVD_HI:`BIT_RSVD_LO] == 2'b00 && !prdata[`BIT_CLEAR]))
        else $error("reserved or clear bit read nonzero");

    a_clear_all_ones: assert property (@(posedge pclk) disable iff (!presetn)
        any_clear |=> ((pif.count == `COUNT_ONES) && (wdt_clear == $past(wdt_uses_tap))))
        else $error("counter not all ones after clear");

    a_clear_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (any_clear && !flag) |=> !flag)
        else $error("flag set in a clear cycle");

    a_wdt_clear_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (any_clear && wdt_uses_tap) |=> (wdt_clear && wdt_tap))
        else $error("watchdog clear or tap phase wrong");

    a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        (pif.tick && !any_clear) |=> (pif.count == $past(pif.count) - 17'h0_0001))
        else $error("count did not step down by one");

    a_flag_keeps_one: assert property (@(posedge pclk) disable iff (!presetn)
        (s_write_one_flag ##0 flag) |=> flag)
        else $error("flag lost on a write of one");

    a_flag_no_spurious: assert property (@(posedge pclk) disable iff (!presetn)
        (!flag && !pif.event_hit) |=> !flag)
        else $error("flag set with no interval");

    a_sub_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (sub_stop_mode && !flag) |=> !flag)
        else $error("flag set in sub-clock stop");

    a_enable_loads: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access |=> (irq_enable == $past(pwdata[`BIT_IRQ_EN])))
        else $error("enable bit not loaded by write");

    a_select_loads: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access |=> (sel == $past(pwdata[`BIT_SEL_HI:`BIT_SEL_LO])))
        else $error("select field not loaded by write");

    a_read_fields: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_setup |=> (prdata[`BIT_IRQ_EN] == $past(irq_enable)
            && prdata[`BIT_SEL_HI:`BIT_SEL_LO] == $past(sel)))
        else $error("enable or select read back wrong");

    a_osc_drop_clear: assert property (@(posedge pclk) disable iff (!presetn)
        s_osc_drop |=> (pif.count == `COUNT_ONES))
        else $error("counter kept after oscillator enable dropped");

    a_stop_entry_clear: assert property (@(posedge pclk) disable iff (!presetn)
        stop_entry_from_sub |=> (pif.count == `COUNT_ONES))
        else $error("counter kept after stop entry");

    a_divider_restart: assert property (@(posedge pclk) disable iff (!presetn)
        any_clear |=> !half_div)
        else $error("divider phase kept across clear");

    a_tick_halves: assert property (@(posedge pclk) disable iff (!presetn)
        (src_rise && !any_clear) |=> (half_div != $past(half_div)))
        else $error("divider did not toggle on source edge");

    a_wdt_clear_gated: assert property (@(posedge pclk) disable iff (!presetn)
        !wdt_uses_tap |=> !wdt_clear)
        else $error("watchdog cleared while not using the tap");

    a_irq_drops_clear: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_zero_flag |=> !irq)
        else $error("request stayed after flag cleared");

endmodule

// >>> sim/irq_wdt_model.sv
// Purpose: far side of the prescaler, interrupt controller and watchdog counter
// Assumes: single pclk domain, irq is a level
// Notes:   counts only, the bench judges the totals
module irq_wdt_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic irq,
    input  wire logic wdt_tap,
    input  wire logic wdt_clear,
    output int        clear_cnt,
    output int        irq_cnt,
    output int        wdt_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tap_d;
    logic irq_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_cnt <= 0;
            wdt_count <= 0;
            tap_d     <= 1'b1;
        end else begin
            tap_d <= wdt_tap;
            if (wdt_clear) begin
                clear_cnt <= clear_cnt + 1;
                wdt_count <= 0;
            end else if (tap_d && !wdt_tap) begin
                wdt_count <= wdt_count + 1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_cnt <= 0;
            irq_d   <= 1'b0;
        end else begin
            irq_d <= irq;
            if (irq && !irq_d) begin
                irq_cnt <= irq_cnt + 1;
            end
        end
    end
endmodule

// >>> sim/testbench.sv
// Purpose: self-checking bench of the interval prescaler
// Assumes: pins toggle at 3 pclk high, 3 low; tick every second rising pin edge
// Notes:   only the shortest interval is timed, longer ones cost too many cycles
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, erv;
    logic        rmw_access, subclk_pin, subrc_pin, sub_osc_enable, subrc_osc_enable;
    logic        sub_stable, subrc_stable, main_clock_mode, sub_stop_mode;
    logic        stop_entry_from_sub, wdt_uses_tap, wdt_tap, wdt_clear, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [15:0] rows [8];
    int          error_cnt, checks_done, clear_cnt, irq_cnt, wdt_count;

    watch_interval_prescaler dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rmw_access(rmw_access), .subclk_pin(subclk_pin), .subrc_pin(subrc_pin),
        .sub_osc_enable(sub_osc_enable), .subrc_osc_enable(subrc_osc_enable), .sub_stable(sub_stable),
        .subrc_stable(subrc_stable), .main_clock_mode(main_clock_mode), .sub_stop_mode(sub_stop_mode),
        .stop_entry_from_sub(stop_entry_from_sub), .wdt_uses_tap(wdt_uses_tap), .wdt_tap(wdt_tap),
        .wdt_clear(wdt_clear), .irq(irq));

    irq_wdt_model partner (.pclk(pclk), .presetn(presetn), .irq(irq), .wdt_tap(wdt_tap),
        .wdt_clear(wdt_clear), .clear_cnt(clear_cnt), .irq_cnt(irq_cnt), .wdt_count(wdt_count));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic results();
        if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // both pins come from the bench; each call moves only the one use_rc picks
    task automatic pulses(input logic use_rc, input int n);
        repeat (n) begin
            repeat (3) @(posedge pclk) if (use_rc) subrc_pin <= 1'b1; else subclk_pin <= 1'b1;
            repeat (3) @(posedge pclk) if (use_rc) subrc_pin <= 1'b0; else subclk_pin <= 1'b0;
        end
        repeat (8) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0000_0000);
    endtask

    initial begin
        #(70000 * 8);
        error_cnt++;
        results();
    end

    initial begin
        {presetn, psel, penable, pwrite, rmw_access, subclk_pin, subrc_pin} = '0;
        {main_clock_mode, sub_stop_mode, stop_entry_from_sub, wdt_uses_tap} = '0;
        {sub_osc_enable, subrc_osc_enable, sub_stable, subrc_stable} = '1;
        paddr  = 12'h000;
        pwdata = 32'h0000_0000;
        // written byte beside the byte that must read back
        rows   = '{16'h3F0E, 16'hF242, 16'h8404, 16'h4646, 16'hB808, 16'h1A0A, 16'h4C4C, 16'h0E0E};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0000_0000);
        `CHK(rdv, 32'h0000_0000)
        `CHK(wdt_tap, 1'b1)
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 12'h000, {24'h00_0000, rows[i][15:8]});
            apb(1'b0, 12'h000, 32'h0000_0000);
            `CHK(rdv, {24'h00_0000, rows[i][7:0]})
            `CHK(irq, 1'b0)
        end
        // unmapped place is refused and leaves the register alone
        apb(1'b1, 12'h004, 32'h0000_00FF);
        `CHK(erv, 1'b1)
        apb(1'b0, 12'h000, 32'h0000_0000);
        `CHK(rdv, {24'h00_0000, rows[7][7:0]})
        wdt_uses_tap <= 1'b1;
        apb(1'b1, 12'h000, 32'h0000_0009);
        // the watchdog side counts the clear on the task's last edge; one more edge lets the bench read it
        @(posedge pclk);
        `CHK(clear_cnt, 1)
        `CHK(wdt_count, 0)
        `CHK(wdt_tap, 1'b1)
        pulses(1'b0, 2046);
        `CHK(rdv[7], 1'b0)
        pulses(1'b0, 2);
        `CHK(rdv[7], 1'b1)
        `CHK(irq, 1'b0)
        apb(1'b1, 12'h000, 32'h0000_00C8);
        `CHK(irq, 1'b1)
        apb(1'b1, 12'h000, 32'h0000_0048); // handler clears the flag
        `CHK(irq, 1'b0)
        `CHK(irq_cnt, 1)
        rmw_access <= 1'b1;
        apb(1'b0, 12'h000, 32'h0000_0000);
        rmw_access <= 1'b0;
        `CHK(rdv[7], 1'b1)
        apb(1'b0, 12'h000, 32'h0000_0000);
        `CHK(rdv[7], 1'b0)
        // sub-rc alone as source, then a stop entry restarts the count
        wdt_uses_tap   <= 1'b0;
        sub_osc_enable <= 1'b0;
        apb(1'b1, 12'h000, 32'h0000_0009);
        `CHK(clear_cnt, 1)
        pulses(1'b1, 1500);
        stop_entry_from_sub <= 1'b1;
        @(posedge pclk);
        stop_entry_from_sub <= 1'b0;
        pulses(1'b1, 2046);
        `CHK(rdv[7], 1'b0)
        pulses(1'b1, 2);
        `CHK(rdv[7], 1'b1)
        `CHK(irq, 1'b0)
        apb(1'b1, 12'h000, 32'h0000_00C8);
        `CHK(irq, 1'b1)
        // reset in mid-run with the request standing
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0000_0000);
        `CHK(rdv, 32'h0000_0000)
        `CHK(irq, 1'b0)
        `CHK(wdt_tap, 1'b1)
        `CHK(irq_cnt, 0)
        // enable dropped in main clocking restarts the count
        apb(1'b1, 12'h000, 32'h0000_0009);
        pulses(1'b1, 600);
        main_clock_mode  <= 1'b1;
        subrc_osc_enable <= 1'b0;
        @(posedge pclk);
        subrc_osc_enable <= 1'b1;
        pulses(1'b1, 2046);
        `CHK(rdv[7], 1'b0)
        // interval passes in sub-clock stop without setting the flag
        sub_stop_mode <= 1'b1;
        pulses(1'b1, 2);
        `CHK(rdv[7], 1'b0)
        sub_stop_mode <= 1'b0;
        results();
    end
endmodule
